/* ppg_pkg.sv */
// Purpose: Constants shared by the prescaled pulse generator
// Assumes: Registers are 8 bits wide, one per 32-bit bus word
// Notes: Offsets are byte addresses on the Avalon-MM slave
package ppg_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_UPPER_CTRL = 8'h00;
  localparam logic [7:0] OFF_LOWER_CTRL = 8'h04;
  localparam logic [7:0] OFF_UPPER_CYCLE = 8'h08;
  localparam logic [7:0] OFF_LOWER_CYCLE = 8'h0C;
  localparam logic [7:0] OFF_UPPER_DUTY = 8'h10;
  localparam logic [7:0] OFF_LOWER_DUTY = 8'h14;
  localparam logic [7:0] OFF_RUN = 8'h18;
  localparam logic [7:0] OFF_INVERT = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;

  // Control register fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int IE_BIT = 5;
  localparam int BORROW_BIT = 4;
  localparam int OUTEN_BIT = 3;
  localparam int CKS_HI = 2;
  localparam int CKS_LO = 0;

  // Writable bits of each control register
  localparam logic [7:0] UPPER_CTRL_MASK = 8'h2F;
  localparam logic [7:0] LOWER_CTRL_MASK = 8'hEF;

  // Operating mode codes
  localparam logic [1:0] MODE_PRESCALED = 2'h1;

  // Bit positions in run, invert, status and mask registers
  localparam int UPPER_BIT = 1;
  localparam int LOWER_BIT = 0;
  localparam logic [7:0] PAIR_MASK = 8'h03;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] PAIR_RESET = 2'h0;

  // Counter value at which a cycle ends and reloads
  localparam logic [7:0] CNT_LAST = 8'h01;
  localparam logic [7:0] CNT_STEP = 8'h01;

  // Unmapped reads return this
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

endpackage

/* ppg_props.sv */
// Purpose: Port-level checks for the prescaled pulse generator
// Assumes: Testbench writes byte lane 0 at aligned addresses
// Notes: Run, invert and mode are shadowed from completed writes
`timescale 1ns/1ps
`default_nettype none
module ppg_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Interrupt and pins
  input wire logic irq,
  input wire logic upper_wave_out,
  input wire logic lower_wave_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic req;
  logic wr_done;
  logic quiet;
  logic [1:0] run_q;
  logic [1:0] inv_q;
  logic [1:0] mode_q;
  logic [3:0] calm_q;
  assign req = avs_read | avs_write;
  assign wr_done = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign quiet = (calm_q == 4'hF);
  // Shadow of the control bits that gate the pins
  always_ff @(posedge clock) begin
    if (rst) begin
      run_q <= 2'h0;
      inv_q <= 2'h0;
      mode_q <= 2'h0;
    end else if (wr_done) begin
      if (avs_address == ppg_pkg::OFF_RUN) run_q <= avs_writedata[1:0];
      if (avs_address == ppg_pkg::OFF_INVERT) inv_q <= avs_writedata[1:0];
      if (avs_address == ppg_pkg::OFF_LOWER_CTRL) mode_q <= avs_writedata[7:6];
    end
  end
  // Cycles since the last write; pins settle through a short pipeline
  always_ff @(posedge clock) begin
    if (rst || wr_done) begin
      calm_q <= 4'h0;
    end else if (!quiet) begin
      calm_q <= calm_q + 4'h1;
    end
  end
  wait_one_a: assert property (avs_waitrequest && req |=> !avs_waitrequest)
    else $error("request not answered after one wait state");
  answer_cause_a: assert property (!avs_waitrequest |-> $past(req) ##1 avs_waitrequest)
    else $error("wait release without a request");
  read_upper_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  mode_gate_a: assert property (quiet && mode_q != ppg_pkg::MODE_PRESCALED |->
    upper_wave_out == inv_q[1] && lower_wave_out == inv_q[0])
    else $error("pins moved outside the prescaled mode");
  upper_idle_a: assert property (quiet && !run_q[1] |-> upper_wave_out == inv_q[1])
    else $error("stopped upper pin not at invert level");
  lower_idle_a: assert property (quiet && !run_q[0] |-> lower_wave_out == inv_q[0])
    else $error("stopped lower pin not at invert level");
  lower_hold_a: assert property (quiet && !run_q[1] |-> $stable(lower_wave_out))
    else $error("lower pin moved while prescaler stopped");
  // Irq is registered behind the flag, so it falls two edges after the write lands
  irq_sticky_a: assert property ($fell(irq) |-> $past(wr_done, 2))
    else $error("interrupt dropped without a write");
  irq_cause_a: assert property ($rose(irq) |-> run_q != 2'h0 || $past(wr_done) ||
    $past(wr_done, 2) || $past(wr_done, 3))
    else $error("interrupt rose with no borrow source");
  // Main scenarios reached
  upper_rise_c: cover property ($rose(upper_wave_out));
  lower_rise_c: cover property ($rose(lower_wave_out));
  irq_rise_c: cover property ($rose(irq));
endmodule
bind prescaled_pulse_generator ppg_props u_props (.clock, .rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq,
  .upper_wave_out, .lower_wave_out);
`default_nettype wire

/* prescaled_pulse_generator.sv */
// Purpose: Two 8-bit down-counters, upper one prescales the lower one
// Assumes: Single 25 MHz clock, synchronous active-high reset
// Notes: Only the prescaler plus pulse generator mode is built
// What this block does
// - Mode code 01 selects prescaler plus generator
// - Upper run bit loads cycle, starts countdown
// - Upper output high from duty match
// - Upper invert bit flips upper pin
// - Lower run bit loads cycle, starts countdown
// - Lower counts each edge of upper output
// - Lower reloads cycle when count reaches one
// - Lower output high from duty match
// - Lower invert bit flips lower pin
// - Lower holds while prescaler is stopped
// - Flat prescaler output never advances lower
// - Borrow sets flag, enabled flag raises interrupt
// - Upper counts on selected prescaler clock
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module prescaled_pulse_generator #(
  parameter int DIV_W = 7
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq,
  // Waveform pins
  output logic upper_wave_out,
  output logic lower_wave_out
);

  // The select field reaches divide by 128, so seven bits at least
  if (DIV_W < 7) begin
    $error("DIV_W must be at least 7");
  end

  // Address match on the word part of a byte address
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr[7:2] == off[7:2]);
  endfunction

  // Divider mask for a select code: all ones in the low sel bits
  function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
    logic [DIV_W-1:0] m;
    m = '0;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(sel)) begin
        m[i] = 1'b1;
      end
    end
    div_mask = m;
  endfunction

  // Register state
  logic [7:0] upper_ctrl_q;
  logic [7:0] lower_ctrl_q;
  logic [7:0] upper_cycle_q;
  logic [7:0] lower_cycle_q;
  logic [7:0] upper_duty_q;
  logic [7:0] lower_duty_q;
  logic [1:0] run_q;
  logic [1:0] invert_q;
  logic [1:0] borrow_flag_q;

  // Bus handshake state
  logic wait_q;
  logic [31:0] rdata_q;
  logic wr_en;
  logic [7:0] wdata;
  logic [7:0] rmux;

  // Prescaler divider
  logic [DIV_W-1:0] div_q;
  logic upper_tick;

  // Upper timer state
  logic upper_go;
  logic upper_active_q;
  logic upper_start;
  logic [7:0] upper_cnt_q;
  logic upper_borrow;
  logic upper_raw_q;
  logic upper_raw_d1_q;
  logic upper_arm1_q;
  logic upper_arm2_q;
  logic upper_edge;
  logic upper_out_q;

  // Lower timer state
  logic lower_go;
  logic lower_active_q;
  logic lower_start;
  logic [7:0] lower_cnt_q;
  logic lower_borrow;
  logic lower_out_q;

  // Interrupt state
  logic irq_q;
  logic mode_ok;

  // A write lands only at the edge where waitrequest is seen low
  assign wr_en = avs_write && !wait_q && avs_byteenable[0];
  assign wdata = avs_writedata[7:0];

  assign mode_ok = (lower_ctrl_q[ppg_pkg::MODE_HI:ppg_pkg::MODE_LO] == ppg_pkg::MODE_PRESCALED);

  // One wait cycle per access, then release for one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else if (wait_q && (avs_read || avs_write)) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Read mux; borrow and enable bits are shown live
  always_comb begin
    rmux = 8'h00;
    if (hit(avs_address, ppg_pkg::OFF_UPPER_CTRL)) begin
      rmux = upper_ctrl_q & ppg_pkg::UPPER_CTRL_MASK;
      rmux[ppg_pkg::BORROW_BIT] = borrow_flag_q[ppg_pkg::UPPER_BIT];
    end else if (hit(avs_address, ppg_pkg::OFF_LOWER_CTRL)) begin
      rmux = lower_ctrl_q & ppg_pkg::LOWER_CTRL_MASK;
      rmux[ppg_pkg::BORROW_BIT] = borrow_flag_q[ppg_pkg::LOWER_BIT];
    end else if (hit(avs_address, ppg_pkg::OFF_UPPER_CYCLE)) begin
      rmux = upper_cycle_q;
    end else if (hit(avs_address, ppg_pkg::OFF_LOWER_CYCLE)) begin
      rmux = lower_cycle_q;
    end else if (hit(avs_address, ppg_pkg::OFF_UPPER_DUTY)) begin
      rmux = upper_duty_q;
    end else if (hit(avs_address, ppg_pkg::OFF_LOWER_DUTY)) begin
      rmux = lower_duty_q;
    end else if (hit(avs_address, ppg_pkg::OFF_RUN)) begin
      rmux = {6'h00, run_q};
    end else if (hit(avs_address, ppg_pkg::OFF_INVERT)) begin
      rmux = {6'h00, invert_q};
    end else if (hit(avs_address, ppg_pkg::OFF_IRQ_STATUS)) begin
      rmux = {6'h00, borrow_flag_q};
    end else if (hit(avs_address, ppg_pkg::OFF_IRQ_MASK)) begin
      rmux[ppg_pkg::UPPER_BIT] = upper_ctrl_q[ppg_pkg::IE_BIT];
      rmux[ppg_pkg::LOWER_BIT] = lower_ctrl_q[ppg_pkg::IE_BIT];
    end
  end

  // Read data captured while waiting, valid when wait drops
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= ppg_pkg::READ_UNMAPPED;
    end else if (wait_q && avs_read) begin
      rdata_q <= {24'h000000, rmux};
    end
  end

  // Control registers; the mask register aliases the enable bits
  always_ff @(posedge clock) begin
    if (rst) begin
      upper_ctrl_q <= ppg_pkg::REG_RESET;
      lower_ctrl_q <= ppg_pkg::REG_RESET;
    end else if (wr_en) begin
      if (hit(avs_address, ppg_pkg::OFF_UPPER_CTRL)) begin
        upper_ctrl_q <= wdata & ppg_pkg::UPPER_CTRL_MASK;
      end
      if (hit(avs_address, ppg_pkg::OFF_LOWER_CTRL)) begin
        lower_ctrl_q <= wdata & ppg_pkg::LOWER_CTRL_MASK;
      end
      if (hit(avs_address, ppg_pkg::OFF_IRQ_MASK)) begin
        upper_ctrl_q[ppg_pkg::IE_BIT] <= wdata[ppg_pkg::UPPER_BIT];
        lower_ctrl_q[ppg_pkg::IE_BIT] <= wdata[ppg_pkg::LOWER_BIT];
      end
    end
  end

  // Cycle and duty registers; counters pick up cycle only on start or reload, duty is compared live
  always_ff @(posedge clock) begin
    if (rst) begin
      upper_cycle_q <= ppg_pkg::REG_RESET;
      lower_cycle_q <= ppg_pkg::REG_RESET;
      upper_duty_q <= ppg_pkg::REG_RESET;
      lower_duty_q <= ppg_pkg::REG_RESET;
    end else if (wr_en) begin
      if (hit(avs_address, ppg_pkg::OFF_UPPER_CYCLE)) begin
        upper_cycle_q <= wdata;
      end
      if (hit(avs_address, ppg_pkg::OFF_LOWER_CYCLE)) begin
        lower_cycle_q <= wdata;
      end
      if (hit(avs_address, ppg_pkg::OFF_UPPER_DUTY)) begin
        upper_duty_q <= wdata;
      end
      if (hit(avs_address, ppg_pkg::OFF_LOWER_DUTY)) begin
        lower_duty_q <= wdata;
      end
    end
  end

  // Run and invert bits
  always_ff @(posedge clock) begin
    if (rst) begin
      run_q <= ppg_pkg::PAIR_RESET;
      invert_q <= ppg_pkg::PAIR_RESET;
    end else if (wr_en) begin
      if (hit(avs_address, ppg_pkg::OFF_RUN)) begin
        run_q <= wdata[1:0] & ppg_pkg::PAIR_MASK[1:0];
      end
      if (hit(avs_address, ppg_pkg::OFF_INVERT)) begin
        invert_q <= wdata[1:0] & ppg_pkg::PAIR_MASK[1:0];
      end
    end
  end

  // Free-running prescaler shared by the select field
  always_ff @(posedge clock) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  assign upper_tick = ((div_q & div_mask(upper_ctrl_q[ppg_pkg::CKS_HI:ppg_pkg::CKS_LO]))
                      == div_mask(upper_ctrl_q[ppg_pkg::CKS_HI:ppg_pkg::CKS_LO]));

  assign upper_go = run_q[ppg_pkg::UPPER_BIT] && mode_ok;
  assign upper_start = upper_go && !upper_active_q;
  // Zero cycle is treated as one, so the counter never wraps
  assign upper_borrow = upper_go && upper_active_q && upper_tick
                        && (upper_cnt_q <= ppg_pkg::CNT_LAST);

  // Rising run detection
  always_ff @(posedge clock) begin
    if (rst) begin
      upper_active_q <= 1'b0;
    end else begin
      upper_active_q <= upper_go;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      upper_cnt_q <= ppg_pkg::REG_RESET;
    end else if (upper_start) begin
      upper_cnt_q <= upper_cycle_q;
    end else if (upper_borrow) begin
      upper_cnt_q <= upper_cycle_q;
    end else if (upper_go && upper_tick) begin
      upper_cnt_q <= upper_cnt_q - ppg_pkg::CNT_STEP;
    end
  end

  // high from duty match to cycle end
  always_ff @(posedge clock) begin
    if (rst) begin
      upper_raw_q <= 1'b0;
      upper_raw_d1_q <= 1'b0;
    end else begin
      upper_raw_q <= upper_cnt_q <= upper_duty_q;
      upper_raw_d1_q <= upper_raw_q;
    end
  end

  // Arming delays hide stale compares before the first load
  always_ff @(posedge clock) begin
    if (rst) begin
      upper_arm1_q <= 1'b0;
      upper_arm2_q <= 1'b0;
    end else begin
      upper_arm1_q <= upper_go && upper_active_q;
      upper_arm2_q <= upper_arm1_q && upper_go;
    end
  end

  // both edges of the upper waveform
  // a flat waveform gives no edge
  assign upper_edge = upper_arm2_q && upper_go && (upper_raw_q != upper_raw_d1_q);

  always_ff @(posedge clock) begin
    if (rst) begin
      upper_out_q <= 1'b0;
    end else begin
      upper_out_q <= ((upper_go && upper_active_q && (upper_cnt_q <= upper_duty_q))
                      ^ invert_q[ppg_pkg::UPPER_BIT]);
    end
  end

  assign lower_go = run_q[ppg_pkg::LOWER_BIT] && mode_ok;
  assign lower_start = lower_go && !lower_active_q;
  // lower select field unused, edges only
  assign lower_borrow = lower_go && lower_active_q && upper_edge
                        && (lower_cnt_q <= ppg_pkg::CNT_LAST);

  // Rising run detection
  always_ff @(posedge clock) begin
    if (rst) begin
      lower_active_q <= 1'b0;
    end else begin
      lower_active_q <= lower_go;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lower_cnt_q <= ppg_pkg::REG_RESET;
    end else if (lower_start) begin
      lower_cnt_q <= lower_cycle_q;
    end else if (lower_borrow) begin
      lower_cnt_q <= lower_cycle_q;
    end else if (lower_go && upper_edge) begin
      lower_cnt_q <= lower_cnt_q - ppg_pkg::CNT_STEP;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lower_out_q <= 1'b0;
    end else begin
      lower_out_q <= ((lower_go && lower_active_q && (lower_cnt_q <= lower_duty_q))
                      ^ invert_q[ppg_pkg::LOWER_BIT]);
    end
  end

  // sticky borrow flags, set beats clear
  // Cleared by a one to status or a zero to the control flag bit
  always_ff @(posedge clock) begin
    if (rst) begin
      borrow_flag_q <= ppg_pkg::PAIR_RESET;
    end else begin
      if (upper_borrow) begin
        borrow_flag_q[ppg_pkg::UPPER_BIT] <= 1'b1;
      end else if (wr_en && hit(avs_address, ppg_pkg::OFF_IRQ_STATUS)
                   && wdata[ppg_pkg::UPPER_BIT]) begin
        borrow_flag_q[ppg_pkg::UPPER_BIT] <= 1'b0;
      end else if (wr_en && hit(avs_address, ppg_pkg::OFF_UPPER_CTRL)
                   && !wdata[ppg_pkg::BORROW_BIT]) begin
        borrow_flag_q[ppg_pkg::UPPER_BIT] <= 1'b0;
      end
      if (lower_borrow) begin
        borrow_flag_q[ppg_pkg::LOWER_BIT] <= 1'b1;
      end else if (wr_en && hit(avs_address, ppg_pkg::OFF_IRQ_STATUS)
                   && wdata[ppg_pkg::LOWER_BIT]) begin
        borrow_flag_q[ppg_pkg::LOWER_BIT] <= 1'b0;
      end else if (wr_en && hit(avs_address, ppg_pkg::OFF_LOWER_CTRL)
                   && !wdata[ppg_pkg::BORROW_BIT]) begin
        borrow_flag_q[ppg_pkg::LOWER_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (borrow_flag_q[ppg_pkg::UPPER_BIT] && upper_ctrl_q[ppg_pkg::IE_BIT])
               || (borrow_flag_q[ppg_pkg::LOWER_BIT] && lower_ctrl_q[ppg_pkg::IE_BIT]);
    end
  end

  // Outputs straight from flops
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq = irq_q;
  assign upper_wave_out = upper_out_q;
  assign lower_wave_out = lower_out_q;

endmodule

`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for the prescaled pulse generator
// Assumes: 25 MHz clock, synchronous reset held four cycles
// Notes: Register rows first, then waveform, interrupt and hold cases
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, upper_wave_out, lower_wave_out;
  logic [31:0] rd;
  int miscompares = 0;
  int checks_done = 0;
  int hu, hl, ru, rl;
  row_t rows [11];
  // Free-running clock
  always #20 clock = ~clock;
  prescaled_pulse_generator u_dut (.clock, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq,
    .upper_wave_out, .lower_wave_out);
  // Single exit point of the run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // One bus cycle; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= ~w;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      miscompares++;
      summarize();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(n, rd, {24'h0, e});
  endtask
  // Count high cycles and rising edges of both pins
  task automatic sample(input int n);
    logic pu, pl;
    hu = 0; hl = 0; ru = 0; rl = 0;
    pu = upper_wave_out;
    pl = lower_wave_out;
    repeat (n) begin
      @(posedge clock);
      hu += (upper_wave_out === 1'b1);
      hl += (lower_wave_out === 1'b1);
      ru += (upper_wave_out === 1'b1 && pu === 1'b0);
      rl += (lower_wave_out === 1'b1 && pl === 1'b0);
      pu = upper_wave_out;
      pl = lower_wave_out;
    end
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
  endtask
  initial begin
    rows = '{'{ppg_pkg::OFF_UPPER_CTRL, 8'hFF, 8'h2F}, '{ppg_pkg::OFF_LOWER_CTRL, 8'h3F, 8'h2F},
      '{ppg_pkg::OFF_UPPER_CYCLE, 8'hA5, 8'hA5}, '{ppg_pkg::OFF_LOWER_CYCLE, 8'h5A, 8'h5A},
      '{ppg_pkg::OFF_UPPER_DUTY, 8'h3C, 8'h3C}, '{ppg_pkg::OFF_LOWER_DUTY, 8'hC3, 8'hC3},
      '{ppg_pkg::OFF_RUN, 8'hFF, 8'h03}, '{ppg_pkg::OFF_INVERT, 8'hFF, 8'h03},
      '{ppg_pkg::OFF_IRQ_STATUS, 8'hFF, 8'h00}, '{ppg_pkg::OFF_IRQ_MASK, 8'h01, 8'h01},
      '{8'h28, 8'hFF, 8'h00}};
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    // Reset values, then write and read back each row
    for (int k = 0; k < 11; k++) rdchk("reset value", rows[k].a, ppg_pkg::REG_RESET);
    for (int k = 0; k < 11; k++) begin
      wr(rows[k].a, rows[k].d);
      rdchk("register", rows[k].a, rows[k].e);
    end
    // A write without byte lane 0 is answered but must not land
    avs_byteenable <= 4'hE;
    wr(ppg_pkg::OFF_UPPER_CYCLE, 8'h11);
    avs_byteenable <= 4'hF;
    rdchk("lane zero off", ppg_pkg::OFF_UPPER_CYCLE, 8'hA5);
    $display("register test done");
    do_reset();
    // Prescaled mode, divide by two, clock select of lower ignored
    wr(ppg_pkg::OFF_UPPER_CTRL, 8'h21);
    wr(ppg_pkg::OFF_LOWER_CTRL, 8'h67);
    wr(ppg_pkg::OFF_UPPER_CYCLE, 8'h04);
    wr(ppg_pkg::OFF_UPPER_DUTY, 8'h02);
    wr(ppg_pkg::OFF_LOWER_CYCLE, 8'h03);
    wr(ppg_pkg::OFF_LOWER_DUTY, 8'h01);
    wr(ppg_pkg::OFF_RUN, 8'h03);
    repeat (40) @(posedge clock);
    sample(48);
    check("upper high", hu, 24);
    check("upper rises", ru, 6);
    check("lower high", hl, 16);
    check("lower rises", rl, 4);
    wr(ppg_pkg::OFF_INVERT, 8'h01);
    repeat (8) @(posedge clock);
    sample(48);
    check("lower inverted", hl, 32);
    $display("waveform test done");
    // Stop with both inverted, then interrupt mask and clear
    wr(ppg_pkg::OFF_RUN, 8'h00);
    wr(ppg_pkg::OFF_INVERT, 8'h03);
    repeat (4) @(posedge clock);
    check("upper idle", upper_wave_out, 1);
    check("lower idle", lower_wave_out, 1);
    rdchk("status", ppg_pkg::OFF_IRQ_STATUS, 8'h03);
    check("irq", irq, 1);
    wr(ppg_pkg::OFF_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clock);
    check("irq masked", irq, 0);
    wr(ppg_pkg::OFF_IRQ_MASK, 8'h02);
    repeat (2) @(posedge clock);
    check("irq unmasked", irq, 1);
    wr(ppg_pkg::OFF_IRQ_STATUS, 8'h02);
    repeat (2) @(posedge clock);
    check("irq cleared", irq, 0);
    rdchk("status", ppg_pkg::OFF_IRQ_STATUS, 8'h01);
    rdchk("lower flag", ppg_pkg::OFF_LOWER_CTRL, 8'h57);
    $display("interrupt test done");
    // Lower alone never counts
    wr(ppg_pkg::OFF_IRQ_STATUS, 8'h03);
    wr(ppg_pkg::OFF_RUN, 8'h01);
    repeat (40) @(posedge clock);
    rdchk("lower held", ppg_pkg::OFF_IRQ_STATUS, 8'h00);
    // Flat prescaler at zero and full duty
    foreach (rows[k]) if (k < 2) begin
      wr(ppg_pkg::OFF_RUN, 8'h00);
      wr(ppg_pkg::OFF_IRQ_STATUS, 8'h03);
      wr(ppg_pkg::OFF_UPPER_DUTY, k == 0 ? 8'h00 : 8'h04);
      wr(ppg_pkg::OFF_RUN, 8'h03);
      repeat (40) @(posedge clock);
      rdchk("flat prescaler", ppg_pkg::OFF_IRQ_STATUS, 8'h02);
    end
    // Mode 00 keeps both stopped
    wr(ppg_pkg::OFF_RUN, 8'h00);
    wr(ppg_pkg::OFF_IRQ_STATUS, 8'h03);
    wr(ppg_pkg::OFF_LOWER_CTRL, 8'h27);
    wr(ppg_pkg::OFF_UPPER_DUTY, 8'h02);
    wr(ppg_pkg::OFF_RUN, 8'h03);
    repeat (40) @(posedge clock);
    rdchk("other mode", ppg_pkg::OFF_IRQ_STATUS, 8'h00);
    $display("hold test done");
    summarize();
  end
endmodule
`default_nettype wire
